// ==== haw_pkg.sv ====
// package: register map, field layout, timing constants and carrier types of the halt wake timer
package haw_pkg;

    // register bus geometry
    localparam int unsigned ADDR_W = 10;
    localparam int unsigned DATA_W = 32;
    localparam int unsigned BE_W   = 4;

    // register indices as printed, byte address is four times the index
    localparam logic [7:0]        IDX_PRESCALER  = 8'h49;
    localparam logic [7:0]        IDX_CONTROL    = 8'h4A;
    localparam logic [ADDR_W-1:0] ADDR_PRESCALER = {IDX_PRESCALER, 2'b00};
    localparam logic [ADDR_W-1:0] ADDR_CONTROL   = {IDX_CONTROL, 2'b00};

    // control/status field positions
    localparam int unsigned CSR_ENABLE_BIT  = 0;
    localparam int unsigned CSR_MEASURE_BIT = 1;
    localparam int unsigned CSR_FLAG_BIT    = 2;

    // values after reset, and the zero prescaler value that a write cannot set
    localparam logic [7:0] PRESCALER_RESET = 8'hFF;
    localparam logic [7:0] CONTROL_RESET   = 8'h00;
    localparam logic [7:0] PRESCALER_ZERO  = 8'h00;

    // fixed divider in front of the prescaler
    localparam int unsigned      FIXED_DIV   = 64;
    localparam int unsigned      FIXED_DIV_W = 6;
    localparam logic [5:0]       FIXED_LAST  = 6'(FIXED_DIV - 1);

    // oscillator stabilisation waits, in cpu cycles
    localparam int unsigned      STAB_W         = 13;
    localparam int unsigned      STAB_SHORT_CYC = 256;
    localparam int unsigned      STAB_LONG_CYC  = 4096;
    localparam logic [STAB_W-1:0] STAB_SHORT_LOAD = 13'(STAB_SHORT_CYC - 1);
    localparam logic [STAB_W-1:0] STAB_LONG_LOAD  = 13'(STAB_LONG_CYC - 1);

    // pll start-up time, a least time so the cycle count rounds up
    localparam int unsigned      CLK_PERIOD_PS   = 8000;
    localparam int unsigned      PLL_START_NS    = 1000;
    localparam int unsigned      PLL_START_CYC   = (PLL_START_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam logic [STAB_W-1:0] PLL_START_LOAD = 13'(PLL_START_CYC - 1);

    // power state of the device
    typedef enum logic [2:0] {
        HAW_RUN,
        HAW_HALT_PLAIN,
        HAW_HALT_TIMED,
        HAW_STABILISE,
        HAW_PLL_WAIT
    } haw_state_t;

    // avalon request from the master
    typedef struct packed {
        logic              read;
        logic              write;
        logic [ADDR_W-1:0] address;
        logic [BE_W-1:0]   byteenable;
        logic [DATA_W-1:0] writedata;
    } haw_bus_req_t;

    // avalon answer to the master
    typedef struct packed {
        logic              waitrequest;
        logic [DATA_W-1:0] readdata;
    } haw_bus_rsp_t;

    // power and clock controls toward the clock controller
    typedef struct packed {
        logic halt_mode;
        logic timed_halt_mode;
        logic main_osc_on;
        logic periph_clk_en;
        logic wake_rc_osc_en;
        logic cpu_run;
    } haw_pwr_t;

endpackage

// ==== haw_wake_counter.sv ====
// wake delay counter: fixed divide-by-64 followed by the programmable prescaler
`timescale 1ns/1ps
module haw_wake_counter
    import haw_pkg::*;
(
    // clock and reset
    input  wire logic       clock,
    input  wire logic       rst_n,
    // control from the power state machine
    input  wire logic       start,
    input  wire logic       run,
    input  wire logic       rc_tick,
    input  wire logic [7:0] prescaler,
    // expiry pulse
    output logic            expired_q
);
    import haw_pkg::*;

    logic [5:0] div_q;
    logic [7:0] pre_q;
    logic [7:0] limit_q;
    logic       done_q;
    wire        div_wrap = (div_q == FIXED_LAST);
    wire        pre_last = (pre_q == 8'(limit_q - 8'h01));
    wire        counting = run && !done_q && rc_tick;

    // restart on each entry, stop once the interrupt was raised
    always_ff @(posedge clock) begin
        if (!rst_n || start) begin
            div_q     <= '0;
            pre_q     <= '0;
            done_q    <= 1'b0;
            expired_q <= 1'b0;
        end else begin
            expired_q <= counting && div_wrap && pre_last;
            if (counting) begin
                div_q <= div_wrap ? '0 : 6'(div_q + 6'h01);
                if (div_wrap) begin
                    pre_q  <= pre_last ? '0 : 8'(pre_q + 8'h01);
                    done_q <= pre_last;
                end
            end
        end
    end

    // prescaler is caught at entry so a later write cannot stretch a running delay
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            limit_q <= PRESCALER_RESET;
        end else if (start) begin
            limit_q <= prescaler;
        end
    end

endmodule

// ==== haw_top.sv ====
// halt wake timer: register slave, power state machine and rc clock handling
//
// Chosen here: register access over Avalon-MM.
`timescale 1ns/1ps
module haw_top
    import haw_pkg::*;
(
    // clock and reset
    input  wire logic                  clock,
    input  wire logic                  rst_n,
    // avalon-mm register slave
    input  wire haw_pkg::haw_bus_req_t bus_req,
    output haw_pkg::haw_bus_rsp_t      bus_rsp,
    // cpu core
    input  wire logic                  halt_exec,
    input  wire logic                  ext_wake_irq,
    input  wire logic [1:0]            wake_irq_priority,
    input  wire logic [1:0]            cpu_irq_level,
    input  wire logic                  cc_popped,
    output logic                       wake_irq,
    output logic                       cc_imask_clear,
    output logic                       svc_start,
    output logic [1:0]                 svc_level,
    // options and watchdog
    input  wire logic                  watchdog_active,
    input  wire logic                  watchdog_halt_option,
    input  wire logic                  stab_long_sel,
    input  wire logic                  pll_enable,
    output logic                       watchdog_reset,
    // clock controller and auto-reload timer
    input  wire logic                  wake_rc_clock,
    output haw_pkg::haw_pwr_t          pwr,
    output logic                       rc_capture
);
    import haw_pkg::*;

    // register state
    logic [7:0]        prescaler_q;
    logic              enable_q;
    logic              measure_q;
    logic              flag_q;
    // bus answer state
    logic              waitrequest_q;
    logic [DATA_W-1:0] readdata_q;
    // power state
    haw_state_t        state_q;
    haw_state_t        state_d;
    logic [STAB_W-1:0] wait_q;
    logic [STAB_W-1:0] wait_d;
    haw_pwr_t          pwr_q;
    // cpu-side pulses and levels
    logic              cc_imask_clear_q;
    logic              svc_start_q;
    logic [1:0]        svc_level_q;
    logic [1:0]        saved_level_q;
    logic              watchdog_reset_q;
    // rc clock synchroniser and edge detect
    logic              rc_meta_q;
    logic              rc_sync_q;
    logic              rc_prev_q;
    logic              rc_capture_q;
    // counter link
    logic              expired;
    // next values and qualifiers, all continuous
    logic              notice;
    logic              waitrequest_d;
    logic [DATA_W-1:0] readdata_d;
    logic [7:0]        prescaler_d;
    logic              enable_d;
    logic              measure_d;
    logic              flag_d;
    logic              in_timed;
    logic              halt_entry;
    logic              wdg_reset_d;

    // decode of the power controls for a state, used for the output register
    function automatic haw_pwr_t pwr_of(input haw_state_t st, input logic meas);
        haw_pwr_t p;
        p.halt_mode       = (st == HAW_HALT_PLAIN) || (st == HAW_HALT_TIMED);
        p.timed_halt_mode = (st == HAW_HALT_TIMED);
        p.main_osc_on     = !p.halt_mode;
        p.periph_clk_en   = (st == HAW_RUN);
        p.wake_rc_osc_en  = p.timed_halt_mode || (meas && (st == HAW_RUN));
        p.cpu_run         = (st == HAW_RUN);
        return p;
    endfunction

    // bus decode; an access completes at the edge where waitrequest is low
    wire req_any      = bus_req.read || bus_req.write;
    wire access       = req_any && !waitrequest_q;
    wire hit_presc    = (bus_req.address == ADDR_PRESCALER);
    wire hit_ctrl     = (bus_req.address == ADDR_CONTROL);
    wire lane0        = bus_req.byteenable[0];
    wire wr_presc     = access && bus_req.write && hit_presc && lane0;
    wire wr_ctrl      = access && bus_req.write && hit_ctrl && lane0;
    wire rd_ctrl      = access && bus_req.read && hit_ctrl;
    wire [7:0] wdata  = bus_req.writedata[7:0];
    wire presc_ok     = (wdata != PRESCALER_ZERO);

    // register images as software sees them
    wire [7:0] ctrl_image  = {5'h00, flag_q, measure_q, enable_q};
    wire [DATA_W-1:0] rd_mux = hit_presc ? {24'h000000, prescaler_q} :
                               hit_ctrl  ? {24'h000000, ctrl_image}  : 32'h00000000;

    // power state decisions
    wire in_run        = (state_q == HAW_RUN);
    wire halt_take     = in_run && halt_exec;
    wire wdg_fires     = watchdog_active && !watchdog_halt_option;
    wire enter_timed   = halt_take && !wdg_fires && enable_q;
    wire enter_plain   = halt_take && !wdg_fires && !enable_q;
    wire rc_edge       = rc_sync_q && !rc_prev_q;
    wire wait_done     = (wait_q == '0);
    wire [STAB_W-1:0] stab_load = stab_long_sel ? STAB_LONG_LOAD : STAB_SHORT_LOAD;

    // bus answer next values; read data are caught when the request is first seen
    assign notice        = req_any && waitrequest_q;
    assign waitrequest_d = !notice;                          // low for exactly one cycle
    assign readdata_d    = bus_req.read ? rd_mux : '0;       // writes return zero

    // answer the master one cycle after a request appears, then rearm
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            waitrequest_q <= 1'b1;
            readdata_q    <= '0;
        end else begin
            waitrequest_q <= waitrequest_d;
            if (notice) begin
                readdata_q <= readdata_d;
            end
        end
    end

    // prescaler next value; a zero write is dropped so the divider never sees zero
    assign prescaler_d = (wr_presc && presc_ok) ? wdata : prescaler_q;

    // prescaler register
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            prescaler_q <= PRESCALER_RESET;
        end else begin
            prescaler_q <= prescaler_d;
        end
    end

    // control bit next values; only a lane-0 write to control/status moves them
    assign enable_d  = wr_ctrl ? wdata[CSR_ENABLE_BIT]  : enable_q;
    assign measure_d = wr_ctrl ? wdata[CSR_MEASURE_BIT] : measure_q;

    // software-owned control bits; reset gives an all-zero register
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            enable_q  <= CONTROL_RESET[CSR_ENABLE_BIT];
            measure_q <= CONTROL_RESET[CSR_MEASURE_BIT];
        end else begin
            enable_q  <= enable_d;
            measure_q <= measure_d;
        end
    end

    // wake flag next value: set by expiry, cleared by a read, never by a write; set wins
    assign flag_d = expired ? 1'b1 : (rd_ctrl ? 1'b0 : flag_q);

    // wake flag register
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            flag_q <= CONTROL_RESET[CSR_FLAG_BIT];
        end else begin
            flag_q <= flag_d;
        end
    end

    // two-stage synchroniser for the rc clock, then a third stage for edges
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            rc_meta_q <= 1'b0;
            rc_sync_q <= 1'b0;
            rc_prev_q <= 1'b0;
        end else begin
            rc_meta_q <= wake_rc_clock;
            rc_sync_q <= rc_meta_q;
            rc_prev_q <= rc_sync_q;
        end
    end

    // measurement route to the timer capture, only in run mode
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            rc_capture_q <= 1'b0;
        end else begin
            rc_capture_q <= measure_q && in_run && rc_sync_q;
        end
    end

    // next power state and wait count
    always_comb begin
        state_d = state_q;
        wait_d  = wait_q;
        unique case (state_q)
            HAW_RUN: begin
                // a halt under watchdog veto stays here
                if (enter_timed) begin
                    state_d = HAW_HALT_TIMED;
                end else if (enter_plain) begin
                    state_d = HAW_HALT_PLAIN;
                end
            end
            HAW_HALT_PLAIN: begin
                // only a halt-exit interrupt ends plain halt
                if (ext_wake_irq) begin
                    state_d = HAW_STABILISE;
                    wait_d  = stab_load;
                end
            end
            HAW_HALT_TIMED: begin
                // a pending interrupt at entry wakes at once
                if (expired || ext_wake_irq) begin
                    state_d = HAW_STABILISE;
                    wait_d  = stab_load;
                end
            end
            HAW_STABILISE: begin
                // count the stabilisation wait down, then the pll if enabled
                if (!wait_done) begin
                    wait_d = STAB_W'(wait_q - 1'b1);
                end else if (pll_enable) begin
                    state_d = HAW_PLL_WAIT;
                    wait_d  = PLL_START_LOAD;
                end else begin
                    state_d = HAW_RUN;
                end
            end
            HAW_PLL_WAIT: begin
                // extra pll start-up after the oscillator is stable
                if (!wait_done) begin
                    wait_d = STAB_W'(wait_q - 1'b1);
                end else begin
                    state_d = HAW_RUN;
                end
            end
            default: begin
                state_d = HAW_RUN;
            end
        endcase
    end

    // state registers; a reset always returns to run
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            state_q <= HAW_RUN;
            wait_q  <= '0;
        end else begin
            state_q <= state_d;
            wait_q  <= wait_d;
        end
    end

    // power controls registered from the next state so they move with it
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            pwr_q <= pwr_of(HAW_RUN, 1'b0);
        end else begin
            pwr_q <= pwr_of(state_d, measure_q);
        end
    end

    // halt entry side effects; a vetoed halt resets instead of clearing the mask
    assign halt_entry  = enter_timed || enter_plain;
    assign wdg_reset_d = halt_take && wdg_fires;

    // halt entry pulses, one cycle each
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            cc_imask_clear_q <= 1'b0;
            watchdog_reset_q <= 1'b0;
        end else begin
            cc_imask_clear_q <= halt_entry;
            watchdog_reset_q <= wdg_reset_d;
        end
    end

    // service start: save the running level, raise to the routine's priority
    wire resume = (state_q != HAW_RUN) && (state_d == HAW_RUN);
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            svc_start_q   <= 1'b0;
            svc_level_q   <= 2'h0;
            saved_level_q <= 2'h0;
        end else begin
            svc_start_q <= resume;
            if (resume) begin
                saved_level_q <= cpu_irq_level;
                svc_level_q   <= wake_irq_priority;
            end else if (cc_popped) begin
                svc_level_q <= saved_level_q;
            end
        end
    end

    // delay counter only runs while in timed halt
    assign in_timed = (state_q == HAW_HALT_TIMED);
    haw_wake_counter i_haw_wake_counter (
        .clock     (clock),
        .rst_n     (rst_n),
        .start     (enter_timed),
        .run       (in_timed),
        .rc_tick   (rc_edge),
        .prescaler (prescaler_q),
        .expired_q (expired)
    );

    // bus answer, straight from registers
    assign bus_rsp.waitrequest = waitrequest_q;
    assign bus_rsp.readdata    = readdata_q;

    // cpu side, straight from registers
    assign wake_irq            = flag_q;
    assign cc_imask_clear      = cc_imask_clear_q;
    assign svc_start           = svc_start_q;
    assign svc_level           = svc_level_q;
    assign watchdog_reset      = watchdog_reset_q;

    // clock controller and timer side, straight from registers
    assign pwr                 = pwr_q;
    assign rc_capture          = rc_capture_q;

endmodule

// ==== haw_checker_props.sv ====
// checker: timing relations seen at the halt wake timer ports
`timescale 1ns/1ps
module haw_checker
    import haw_pkg::*;
(
    // clock and reset
    input wire logic                  clock,
    input wire logic                  rst_n,
    // register bus
    input wire haw_pkg::haw_bus_req_t bus_req,
    input wire haw_pkg::haw_bus_rsp_t bus_rsp,
    // cpu and options
    input wire logic                  halt_exec,
    input wire logic                  watchdog_active,
    input wire logic                  watchdog_halt_option,
    input wire logic                  wake_irq,
    input wire logic                  cc_imask_clear,
    input wire logic                  svc_start,
    input wire logic                  watchdog_reset,
    // power and capture
    input wire haw_pkg::haw_pwr_t     pwr,
    input wire logic                  rc_capture
);
    import haw_pkg::*;

    default clocking @(posedge clock); endclocking
    default disable iff (!rst_n);
    logic [12:0] stab_q;
    // a read of control/status completes here, the only thing allowed to drop the flag
    wire rd_ctl = bus_req.read && !bus_rsp.waitrequest && (bus_req.address == ADDR_CONTROL);
    // cycles with the oscillator on and the cpu held; saturates so a stuck wait cannot wrap
    always_ff @(posedge clock) begin
        if (!rst_n || pwr.cpu_run) stab_q <= 13'h0000;
        else if (pwr.main_osc_on && stab_q != 13'h1FFF) stab_q <= stab_q + 13'h0001;
    end
    sequence s_halt_req;
        halt_exec && pwr.cpu_run;
    endsequence
    sequence s_wdg_veto;
        watchdog_active && !watchdog_halt_option;
    endsequence
    AST_BUS_ANSWER: assert property ((bus_req.read || bus_req.write) && bus_rsp.waitrequest |=> !bus_rsp.waitrequest)
        else $error("bus request not answered after one wait cycle");
    AST_BUS_PULSE: assert property (!bus_rsp.waitrequest |=> bus_rsp.waitrequest)
        else $error("waitrequest low for more than one cycle");
    AST_RSV_ZERO: assert property (!bus_rsp.waitrequest |-> bus_rsp.readdata[31:8] == 24'h000000)
        else $error("upper read data bits not zero");
    AST_HALT_ENTER: assert property (s_halt_req ##0 !(watchdog_active && !watchdog_halt_option)
        |=> pwr.halt_mode && !pwr.cpu_run && cc_imask_clear)
        else $error("halt not entered with mask clear");
    AST_WDG_RESET: assert property (s_halt_req ##0 s_wdg_veto |=> watchdog_reset && pwr.cpu_run)
        else $error("watchdog reset missing on vetoed halt");
    AST_TIMED_POWER: assert property (pwr.timed_halt_mode |-> !pwr.main_osc_on && !pwr.periph_clk_en
        && pwr.wake_rc_osc_en)
        else $error("wrong clocks during timed halt");
    AST_WAKE_OSC: assert property ($rose(wake_irq) |-> pwr.main_osc_on && !pwr.cpu_run && !pwr.halt_mode)
        else $error("oscillator not restarted on wake");
    AST_STAB_LEN: assert property ($rose(pwr.cpu_run) |-> stab_q >= 13'h0100)
        else $error("cpu resumed before stabilisation wait");
    AST_SVC_AFTER: assert property ($rose(pwr.cpu_run) |-> ##[0:1] svc_start)
        else $error("service start missing after resume");
    AST_FLAG_HOLD: assert property (wake_irq && !rd_ctl |=> wake_irq)
        else $error("wake flag dropped without a status read");
    AST_CAP_HALT: assert property (pwr.halt_mode && $past(pwr.halt_mode) |-> !rc_capture)
        else $error("capture routed outside run");
endmodule

bind haw_top haw_checker i_haw_checker (.clock, .rst_n, .bus_req, .bus_rsp, .halt_exec, .watchdog_active,
    .watchdog_halt_option, .wake_irq, .cc_imask_clear, .svc_start, .watchdog_reset, .pwr, .rc_capture);

// ==== haw_far.sv ====
// far side model: wake rc oscillator of the clock controller
`timescale 1ns/1ps
module haw_far
    import haw_pkg::*;
#(
    parameter int RC_START_NS = 40,
    parameter int RC_HALF_NS  = 13
)(
    // power controls from the block
    input wire haw_pkg::haw_pwr_t pwr,
    // oscillator output
    output logic                  wake_rc_clock
);
    import haw_pkg::*;

    // stands at zero while disabled and pays its start-up time on every enable
    initial begin
        wake_rc_clock = 1'b0;
        forever begin
            wait (pwr.wake_rc_osc_en === 1'b1);
            #(RC_START_NS);
            while (pwr.wake_rc_osc_en === 1'b1) begin
                #(RC_HALF_NS) wake_rc_clock = ~wake_rc_clock;
            end
            wake_rc_clock = 1'b0;
        end
    end
endmodule

// ==== haw_top_tb.sv ====
// testbench: register, halt and wake scenarios for the halt wake timer
`timescale 1ns/1ps
module haw_top_tb;
    import haw_pkg::*;
    haw_bus_req_t bus_req;
    haw_bus_rsp_t bus_rsp;
    haw_pwr_t     pwr;
    logic         clock;
    logic         rst_n = 1'b0;
    logic         halt_exec = 1'b0, ext_wake_irq = 1'b0, cc_popped = 1'b0, watchdog_active = 1'b0;
    logic         watchdog_halt_option = 1'b1, stab_long_sel = 1'b0, pll_enable = 1'b0;
    logic         wake_rc_clock, wake_irq, cc_imask_clear, svc_start, watchdog_reset, rc_capture;
    logic [1:0]   wake_irq_priority = 2'h2, cpu_irq_level = 2'h1, svc_level;
    logic [31:0]  rdata;
    int           mismatches = 0, checks_done = 0, cyc = 0, rc_edges = 0, n_clr = 0, n_wdr = 0, n_cap = 0, n;
    int           n_svc = 0;

    haw_top i_haw_top (.clock, .rst_n, .bus_req, .bus_rsp, .halt_exec, .ext_wake_irq, .wake_irq_priority,
        .cpu_irq_level, .cc_popped, .wake_irq, .cc_imask_clear, .svc_start, .svc_level, .watchdog_active,
        .watchdog_halt_option, .stab_long_sel, .pll_enable, .watchdog_reset, .wake_rc_clock, .pwr, .rc_capture);
    haw_far i_haw_far (.pwr, .wake_rc_clock);

    // 125 MHz clock
    initial begin
        clock = 1'b0;
        forever #4 clock = ~clock;
    end
    // event counters and hang guard; the ceiling sits well above the longest wake path
    always @(posedge wake_rc_clock) rc_edges++;
    always @(posedge rc_capture) n_cap++;
    always @(posedge clock) begin
        n_clr += int'(cc_imask_clear === 1'b1);
        n_wdr += int'(watchdog_reset === 1'b1);
        n_svc += int'(svc_start === 1'b1);
        cyc++;
        if (cyc == 20000) begin
            mismatches++;
            complete_run();
        end
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            mismatches++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic rng(input int got, input int lo, input int hi);
        checks_done++;
        if (got < lo || got > hi) begin
            mismatches++;
            $display("CHECK FAILED t=%0t got=%h exp=%h..%h", $time, got, lo, hi);
        end
    endtask
    // one access, held until the rising edge that samples waitrequest low; data taken at that edge
    task automatic bus(input logic wr, input logic [ADDR_W-1:0] a, input logic [7:0] d);
        @(posedge clock);
        bus_req.read <= !wr;
        bus_req.write <= wr;
        bus_req.address <= a;
        bus_req.writedata <= {24'h000000, d};
        @(posedge clock);
        while (bus_rsp.waitrequest !== 1'b0) @(posedge clock);
        rdata = bus_rsp.readdata;
        bus_req.read <= 1'b0;
        bus_req.write <= 1'b0;
    endtask
    task automatic pulse_halt();
        @(posedge clock);
        halt_exec <= 1'b1;
        @(posedge clock);
        halt_exec <= 1'b0;
        @(negedge clock);
    endtask
    task automatic wait_run();
        n = 0;
        while (pwr.cpu_run !== 1'b1 && n < 6000) begin
            @(negedge clock);
            n++;
        end
    endtask
    // timed halt with prescaler p: rc edges to the wake flag, stabilisation, flag read-clear
    task automatic timed(input logic [7:0] p);
        bus(1'b1, ADDR_PRESCALER, p);
        bus(1'b1, ADDR_CONTROL, 8'h01);
        repeat (4) @(posedge clock);  // let the rc oscillator stop so entry pays its start-up
        pulse_halt();
        rc_edges = 0;
        chk(pwr.timed_halt_mode, 1'b1);
        chk(pwr.main_osc_on, 1'b0);
        n = 0;
        while (wake_irq !== 1'b1 && n < 3000) begin
            @(negedge clock);
            n++;
        end
        rng(rc_edges, 64 * int'(p), 64 * int'(p) + 2);
        wait_run();
        rng(n, 256, 258);
        repeat (2) @(negedge clock);
        chk(svc_level, wake_irq_priority);
        bus(1'b0, ADDR_CONTROL, 8'h00);
        chk(rdata, 32'h00000005);
        bus(1'b0, ADDR_CONTROL, 8'h00);
        chk(rdata, 32'h00000001);
        chk(wake_irq, 1'b0);
    endtask
    task automatic complete_run();
        $display("mismatches=%0d checks_done=%0d", mismatches, checks_done);
        if (mismatches == 0 && checks_done > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask

    // main sequence
    initial begin
        bus_req = '0;
        bus_req.byteenable = 4'hF;
        repeat (12) @(posedge clock);
        rst_n <= 1'b1;
        bus(1'b0, ADDR_PRESCALER, 8'h00);
        chk(rdata, 32'h000000FF);
        bus(1'b0, ADDR_CONTROL, 8'h00);
        chk(rdata, 32'h00000000);
        bus(1'b0, 10'h3F0, 8'h00);
        chk(rdata, 32'h00000000);
        bus(1'b1, ADDR_PRESCALER, PRESCALER_ZERO);
        bus(1'b0, ADDR_PRESCALER, 8'h00);
        chk(rdata, 32'h000000FF);
        bus(1'b1, ADDR_CONTROL, 8'h07);
        bus(1'b0, ADDR_CONTROL, 8'h00);
        chk(rdata, 32'h00000003);
        n_cap = 0;
        repeat (100) @(negedge clock);
        chk(pwr.wake_rc_osc_en, 1'b1);
        rng(n_cap, 20, 40);
        timed(8'h01);
        timed(8'h02);
        chk(n_clr, 32'h00000002);
        chk(n_svc, 32'h00000002);
        @(posedge clock);
        cc_popped <= 1'b1;
        @(posedge clock);
        cc_popped <= 1'b0;
        repeat (2) @(negedge clock);
        chk(svc_level, cpu_irq_level);
        bus(1'b1, ADDR_CONTROL, 8'h00);
        stab_long_sel <= 1'b1;
        pll_enable <= 1'b1;
        pulse_halt();
        chk(pwr.timed_halt_mode, 1'b0);
        repeat (50) @(negedge clock);
        chk(pwr.halt_mode, 1'b1);
        @(posedge clock);
        ext_wake_irq <= 1'b1;
        wait_run();
        rng(n, 4221, 4226);
        bus(1'b1, ADDR_CONTROL, 8'h01);
        pulse_halt();
        chk(pwr.timed_halt_mode, 1'b1);
        wait_run();
        rng(n, 4221, 4226);
        @(posedge clock);
        ext_wake_irq <= 1'b0;
        watchdog_active <= 1'b1;
        watchdog_halt_option <= 1'b0;
        pulse_halt();
        @(negedge clock);
        chk(n_wdr, 32'h00000001);
        chk(pwr.cpu_run, 1'b1);
        complete_run();
    end
endmodule
